// ### src/dso_boost_hyst.sv
// two-threshold hysteresis for the second-stage boost flag.
// assumes tick, run and feedback are already on clk_sys.
`timescale 1ns/1ps
module dso_boost_hyst #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  // sample inputs
  input  wire logic         tick,
  input  wire logic         run,
  input  wire logic [W-1:0] fb,
  input  wire logic [W-1:0] lim_low,
  input  wire logic [W-1:0] lim_high,
  // flag
  output logic              boost_q
);
  logic boost_d;
  wire  below_low  = fb < lim_low;
  wire  above_high = fb > lim_high;

  // stop wins at once, not only at the next tick, so the second drive halts promptly
  always_comb begin
    boost_d = boost_q;
    if (!run) begin
      boost_d = 1'b0;
    end else if (tick && below_low) begin
      boost_d = 1'b1;
    end else if (tick && above_high) begin
      boost_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) boost_q <= 1'b0;
    else        boost_q <= boost_d;
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_boost_band_hold: assert property (tick && run && !below_low && !above_high |=> $stable(boost_q))
    else $error("boost changed inside band");
  a_boost_low_set: assert property (tick && run && below_low |=> boost_q)
    else $error("boost not set below low limit");
endmodule

// ### src/dso_pkg.sv
// constants shared by the status-flag block: register map, field layout,
// function codes and reset values.
// assumes a 32-bit apb bus with 8 address bits decoded.
package dso_pkg;
  localparam int          AW             = 8;
  localparam int          DW             = 32;
  localparam int          CODE_W         = 8;
  // byte offsets of the register words
  localparam logic [7:0]  OFS_TERM_CFG   = 8'h00;
  localparam logic [7:0]  OFS_START_FREQ = 8'h04;
  localparam logic [7:0]  OFS_CURR_THR   = 8'h08;
  localparam logic [7:0]  OFS_PV_HIGH    = 8'h0C;
  localparam logic [7:0]  OFS_PV_LOW     = 8'h10;
  localparam logic [7:0]  OFS_FLAGS      = 8'h14;
  localparam logic [7:0]  OFS_IRQ_STS    = 8'h18;
  localparam logic [7:0]  OFS_IRQ_MASK   = 8'h1C;
  // terminal config fields
  localparam int          POS_T11        = 0;
  localparam int          POS_T12        = 8;
  localparam int          POS_RELAY      = 16;
  // flag vector bit positions (also irq status layout)
  localparam int          NFLAG          = 4;
  localparam int          FL_POS         = 0;
  localparam int          FL_VLOSS       = 1;
  localparam int          FL_CLOSS       = 2;
  localparam int          FL_BOOST       = 3;
  localparam int          FL_TERM        = 4;
  // output function codes
  localparam logic [7:0]  FN_POS_DONE    = 8'h17;
  localparam logic [7:0]  FN_VOLT_LOSS   = 8'h1B;
  localparam logic [7:0]  FN_CURR_LOSS   = 8'h1C;
  localparam logic [7:0]  FN_BOOST       = 8'h1F;
  // current loop scaling: input lsb in microamps, loss level in microamps
  localparam int          CURR_LSB_UA    = 10;
  localparam int          CURR_LOSS_UA   = 4000;
  localparam logic [15:0] CURR_THR_RST   = 16'(CURR_LOSS_UA / CURR_LSB_UA);
  localparam logic [15:0] START_FREQ_RST = 16'h0000;
  localparam logic [15:0] PV_HIGH_RST    = 16'h0000;
  localparam logic [15:0] PV_LOW_RST     = 16'h0000;
  localparam logic [23:0] TERM_CFG_RST   = 24'h000000;

  // maps a terminal's function code onto the flag it carries
  function automatic logic fn_select(input logic [7:0] code, input logic [NFLAG-1:0] fl);
    logic r;
    r = 1'b0;
    case (code)
      FN_POS_DONE:  r = fl[FL_POS];
      FN_VOLT_LOSS: r = fl[FL_VLOSS];
      FN_CURR_LOSS: r = fl[FL_CLOSS];
      FN_BOOST:     r = fl[FL_BOOST];
      default:      r = 1'b0;
    endcase
    return r;
  endfunction
endpackage

// ### src/dso_status_flags.sv
// status-flag generator for assignable output terminals, with apb registers.
// assumes one clock; position and run come from pins, samples from same-clock logic.
//
// Summary of operation
// - code 23 terminal shows positioning done, low while not done.
// - terminals 11, 12 and relay each pick a flag by function code.
// - code 27 terminal is high while voltage input loss is seen.
// - code 28 terminal is high while current input loss is seen.
// - voltage loss when voltage sample is below start-frequency value.
// - current loss when current sample is below the 4 mA threshold.
// - loss flags clear by themselves once input recovers.
// - signal loss never raises a trip or fault.
// - loss flags are evaluated whether stopped or running.
// - once running, boost flag sets if feedback is below low limit.
// - boost flag clears when feedback exceeds high limit.
// - between the limits the boost flag keeps its state.
// - boost re-sets whenever feedback falls below low limit during run.
// - leaving run forces the boost flag low.
// - boost may rise only in run with feedback below low limit.
`timescale 1ns/1ps
module dso_status_flags #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  // apb slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [dso_pkg::AW-1:0] paddr,
  input  wire logic [dso_pkg::DW-1:0] pwdata,
  input  wire logic [3:0]             pstrb,
  output logic                        pready,
  output logic                        pslverr,
  output logic [dso_pkg::DW-1:0]      prdata,
  // pins from the drive
  input  wire logic                   position_done_in,
  input  wire logic                   run_cmd_in,
  // samples from the control loop
  input  wire logic                   sample_tick,
  input  wire logic [W-1:0]           volt_analog_in,
  input  wire logic [W-1:0]           current_analog_in,
  input  wire logic [W-1:0]           process_feedback,
  // output terminals
  output logic                        term_11_q,
  output logic                        term_12_q,
  output logic                        relay_contact_a,
  output logic                        relay_contact_b,
  // interrupt
  output logic                        irq
);
  // reset release and pin synchronisers
  logic rst_m_q, rst_sync_n;
  logic pos_m_q, pos_s_q;
  logic run_m_q, run_s_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_m_q    <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_m_q    <= 1'b1;
      rst_sync_n <= rst_m_q;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pos_m_q <= 1'b0;
      pos_s_q <= 1'b0;
      run_m_q <= 1'b0;
      run_s_q <= 1'b0;
    end else begin
      pos_m_q <= position_done_in;
      pos_s_q <= pos_m_q;
      run_m_q <= run_cmd_in;
      run_s_q <= run_m_q;
    end
  end

  // configuration registers
  logic [23:0]                term_cfg_q;
  logic [15:0]                start_freq_q;
  logic [15:0]                curr_thr_q;
  logic [15:0]                pv_high_q;
  logic [15:0]                pv_low_q;
  logic [dso_pkg::NFLAG-1:0]  irq_sts_q;
  logic [dso_pkg::NFLAG-1:0]  irq_mask_q;
  logic [dso_pkg::DW-1:0]     prdata_q;

  // apb decode
  wire setup_rd  = psel && !penable && !pwrite;
  wire access    = psel && penable;
  wire wr_en     = access && pwrite;
  wire hit_cfg   = paddr == dso_pkg::OFS_TERM_CFG;
  wire hit_sf    = paddr == dso_pkg::OFS_START_FREQ;
  wire hit_ct    = paddr == dso_pkg::OFS_CURR_THR;
  wire hit_hi    = paddr == dso_pkg::OFS_PV_HIGH;
  wire hit_lo    = paddr == dso_pkg::OFS_PV_LOW;
  wire hit_fl    = paddr == dso_pkg::OFS_FLAGS;
  wire hit_is    = paddr == dso_pkg::OFS_IRQ_STS;
  wire hit_im    = paddr == dso_pkg::OFS_IRQ_MASK;
  wire mapped    = hit_cfg | hit_sf | hit_ct | hit_hi | hit_lo | hit_fl | hit_is | hit_im;
  // flags are read-only; a write there is refused like an unmapped one
  wire bad_acc   = !mapped || (pwrite && hit_fl);
  wire wr_ok     = wr_en && !bad_acc;

  assign pready  = 1'b1;
  assign pslverr = access && bad_acc;
  assign prdata  = prdata_q;

  // byte-lane merge of a register with write data
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) r[8*i +: 8] = wd[8*i +: 8];
    end
    return r;
  endfunction

  wire [31:0] cfg_new = lane_merge({8'h00, term_cfg_q}, pwdata, pstrb);
  wire [31:0] sf_new  = lane_merge({16'h0000, start_freq_q}, pwdata, pstrb);
  wire [31:0] ct_new  = lane_merge({16'h0000, curr_thr_q}, pwdata, pstrb);
  wire [31:0] hi_new  = lane_merge({16'h0000, pv_high_q}, pwdata, pstrb);
  wire [31:0] lo_new  = lane_merge({16'h0000, pv_low_q}, pwdata, pstrb);
  wire [31:0] im_new  = lane_merge({28'h0000000, irq_mask_q}, pwdata, pstrb);

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      term_cfg_q   <= dso_pkg::TERM_CFG_RST;
      start_freq_q <= dso_pkg::START_FREQ_RST;
      curr_thr_q   <= dso_pkg::CURR_THR_RST;
      pv_high_q    <= dso_pkg::PV_HIGH_RST;
      pv_low_q     <= dso_pkg::PV_LOW_RST;
      irq_mask_q   <= '0;
    end else if (wr_ok) begin
      if (hit_cfg) term_cfg_q   <= cfg_new[23:0];
      if (hit_sf)  start_freq_q <= sf_new[15:0];
      if (hit_ct)  curr_thr_q   <= ct_new[15:0];
      if (hit_hi)  pv_high_q    <= hi_new[15:0];
      if (hit_lo)  pv_low_q     <= lo_new[15:0];
      if (hit_im)  irq_mask_q   <= im_new[dso_pkg::NFLAG-1:0];
    end
  end

  // flag evaluation
  logic                       pos_flag_q;
  logic                       vloss_q;
  logic                       closs_q;
  logic                       seen_q;
  logic                       second_stage_boost_flag;
  logic [dso_pkg::NFLAG-1:0]  flags_q;

  // loss checks run regardless of run state, and feed no trip path
  wire vloss_now = volt_analog_in < W'(start_freq_q);
  wire closs_now = current_analog_in < W'(curr_thr_q);

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pos_flag_q <= 1'b0;
      vloss_q    <= 1'b0;
      closs_q    <= 1'b0;
      seen_q     <= 1'b0;
    end else if (sample_tick) begin
      pos_flag_q <= pos_s_q;
      vloss_q    <= vloss_now;
      closs_q    <= closs_now;
      seen_q     <= 1'b1;
    end
  end

  dso_boost_hyst #(
    .W        (W)
  ) u_boost (
    .clk_sys  (clk_sys),
    .rst_n    (rst_sync_n),
    .tick     (sample_tick),
    .run      (run_s_q),
    .fb       (process_feedback),
    .lim_low  (W'(pv_low_q)),
    .lim_high (W'(pv_high_q)),
    .boost_q  (second_stage_boost_flag)
  );

  always_comb begin
    flags_q                    = '0;
    flags_q[dso_pkg::FL_POS]   = pos_flag_q;
    flags_q[dso_pkg::FL_VLOSS] = vloss_q;
    flags_q[dso_pkg::FL_CLOSS] = closs_q;
    flags_q[dso_pkg::FL_BOOST] = second_stage_boost_flag;
  end

  // output terminals; a boost terminal is wired as the forward run of a second drive
  logic relay_q;
  genvar g;
  for (g = 0; g < 3; g++) begin : g_term
    logic t_q;
    dso_term_sel u_sel (
      .clk_sys (clk_sys),
      .rst_n   (rst_sync_n),
      .code    (term_cfg_q[8*g +: 8]),
      .flags   (flags_q),
      .term_q  (t_q)
    );
  end
  assign term_11_q = g_term[0].t_q;
  assign term_12_q = g_term[1].t_q;
  assign relay_q   = g_term[2].t_q;

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      relay_contact_a <= 1'b0;
      relay_contact_b <= 1'b0;
    end else begin
      relay_contact_a <= relay_q;
      relay_contact_b <= ~relay_q;
    end
  end

  // interrupts: rising flag edges, sticky, write one to clear, set wins
  logic [dso_pkg::NFLAG-1:0] flags_prev_q;
  wire  [dso_pkg::NFLAG-1:0] rise   = flags_q & ~flags_prev_q;
  wire  [dso_pkg::NFLAG-1:0] w1c    = (wr_ok && hit_is) ? pwdata[dso_pkg::NFLAG-1:0] : '0;
  wire  [dso_pkg::NFLAG-1:0] sts_d  = (irq_sts_q & ~w1c) | rise;

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      flags_prev_q <= '0;
      irq_sts_q    <= '0;
    end else begin
      flags_prev_q <= flags_q;
      irq_sts_q    <= sts_d;
    end
  end
  assign irq = |(irq_sts_q & irq_mask_q);

  // read data is captured in the setup phase so it stands through the access phase
  wire [31:0] fl_word = {25'h0000000, relay_q, term_12_q, term_11_q, flags_q};
  wire [31:0] rd_mux  = hit_cfg ? {8'h00, term_cfg_q} :
                        hit_sf  ? {16'h0000, start_freq_q} :
                        hit_ct  ? {16'h0000, curr_thr_q} :
                        hit_hi  ? {16'h0000, pv_high_q} :
                        hit_lo  ? {16'h0000, pv_low_q} :
                        hit_fl  ? fl_word :
                        hit_is  ? {28'h0000000, irq_sts_q} :
                        hit_im  ? {28'h0000000, irq_mask_q} : 32'h00000000;

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n)   prdata_q <= '0;
    else if (setup_rd) prdata_q <= rd_mux;
  end

  // checks
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_sync_n);

  a_pos_flag_follow: assert property (sample_tick |=> pos_flag_q == $past(pos_s_q))
    else $error("positioning flag wrong after tick");
  a_vloss_compare: assert property (sample_tick |=> vloss_q == $past(vloss_now))
    else $error("voltage loss flag wrong after tick");
  a_closs_compare: assert property (sample_tick |=> closs_q == $past(closs_now))
    else $error("current loss flag wrong after tick");
  a_loss_self_clear: assert property (vloss_q && sample_tick && !vloss_now |=> !vloss_q)
    else $error("voltage loss flag did not clear");
  a_boost_stop_low: assert property (!run_s_q |=> !second_stage_boost_flag)
    else $error("boost high while stopped");
  a_boost_rise_cause: assert property ($rose(second_stage_boost_flag) |->
      $past(run_s_q) && $past(sample_tick) && $past(process_feedback < W'(pv_low_q)))
    else $error("boost rose without cause");
  a_boost_high_clear: assert property (sample_tick && run_s_q && process_feedback > W'(pv_high_q) &&
      !(process_feedback < W'(pv_low_q)) |=> !second_stage_boost_flag)
    else $error("boost not cleared above high limit");
  a_flags_idle_reset: assert property (!seen_q |-> !pos_flag_q && !vloss_q && !closs_q)
    else $error("flag set before first sample");
  a_term_delay: assert property (sample_tick && term_cfg_q[7:0] == dso_pkg::FN_VOLT_LOSS &&
      $stable(term_cfg_q) ##1 $stable(term_cfg_q) |=> term_11_q == $past(vloss_now, 2))
    else $error("terminal 11 not one edge behind flag");
  a_sticky_set_wins: assert property (|rise |=> (irq_sts_q & $past(rise)) == $past(rise))
    else $error("irq event lost");
endmodule

// ### src/dso_term_sel.sv
// one assignable output terminal: picks a flag by function code and registers it.
// assumes code and flags are on clk_sys.
`timescale 1ns/1ps
module dso_term_sel (
  // clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  // selection
  input  wire logic [7:0]             code,
  input  wire logic [dso_pkg::NFLAG-1:0] flags,
  // terminal
  output logic                        term_q
);
  wire sel = dso_pkg::fn_select(code, flags);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) term_q <= 1'b0;
    else        term_q <= sel;
  end

  a_term_follow: assert property (@(posedge clk_sys) disable iff (!rst_n) ##1 term_q == $past(sel))
    else $error("terminal did not follow selected flag");
endmodule

// ### testbench/dso_second_drive.sv
// behavioural model of the second drive fed by the boost terminal.
// assumes its run input comes straight from a registered terminal on clk_sys.
`timescale 1ns/1ps
module dso_second_drive #(
  parameter int LAG = 2
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // command from the first drive
  input  wire logic forward_run_cmd,
  // motor state
  output logic      motor_fwd_q
);
  // a real drive needs a few cycles to act, so the bench must not expect instant response
  logic [3:0] lag_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lag_q       <= 4'h0;
      motor_fwd_q <= 1'b0;
    end else if (forward_run_cmd == motor_fwd_q) begin
      lag_q <= 4'h0;
    end else if (lag_q >= 4'(LAG)) begin
      motor_fwd_q <= forward_run_cmd;
      lag_q       <= 4'h0;
    end else begin
      lag_q <= lag_q + 4'h1;
    end
  end
endmodule

// ### testbench/tb.sv
// self-checking bench for the status-flag block.
// assumes the block answers apb with zero wait states and a 20 MHz clock.
`timescale 1ns/1ps
module tb;
  logic        clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic        pos_in, run_in, tick, t11, t12, rly_a, rly_b, err, motor;
  logic [15:0] volt, curr, fb;
  int          failures, cmp_count;

  dso_status_flags #(.W(16)) DUT (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .position_done_in(pos_in), .run_cmd_in(run_in), .sample_tick(tick),
    .volt_analog_in(volt), .current_analog_in(curr), .process_feedback(fb),
    .term_11_q(t11), .term_12_q(t12), .relay_contact_a(rly_a), .relay_contact_b(rly_b), .irq(irq));

  dso_second_drive #(.LAG(2)) drive2 (
    .clk_sys(clk_sys), .rst_n(rst_n), .forward_run_cmd(t11), .motor_fwd_q(motor));

  always #25 clk_sys = ~clk_sys;

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d; pstrb <= 4'hF;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (n >= 20) begin
      failures++;
      report_and_stop();
    end
  endtask

  // let pins pass their synchronisers, pulse one sample tick, wait out the pipeline
  task automatic sample;
    repeat (3) @(posedge clk_sys);
    tick <= 1'b1;
    @(posedge clk_sys);
    tick <= 1'b0;
    repeat (5) @(posedge clk_sys);
    #1;
  endtask

  task automatic t_reset_regs;
    chk(rly_b, 1'b1);
    apb(0, dso_pkg::OFS_TERM_CFG, 0);   chk(rd, 32'h0);
    apb(0, dso_pkg::OFS_CURR_THR, 0);   chk(rd, 32'h190);
    apb(0, dso_pkg::OFS_FLAGS, 0);      chk(rd, 32'h0);
    apb(0, dso_pkg::OFS_IRQ_MASK, 0);   chk(rd, 32'h0);
    apb(0, 8'h20, 0);                   chk(rd, 32'h0);
    chk(err, 1'b1);
    apb(1, dso_pkg::OFS_FLAGS, 32'hF);  chk(err, 1'b1);
    $display("test reset_regs done");
  endtask

  task automatic t_position;
    apb(1, dso_pkg::OFS_TERM_CFG, 32'h001B17); // relay off, 12 volt loss, 11 pos done
    pos_in <= 1'b1;
    sample();
    chk({t11, t12, rly_a, rly_b}, 4'b1001);
    pos_in <= 1'b0;
    sample();
    chk(t11, 1'b0);
    $display("test position done");
  endtask

  task automatic t_loss(input logic run);
    run_in <= run;
    apb(1, dso_pkg::OFS_TERM_CFG, 32'h1C1B00);
    apb(1, dso_pkg::OFS_START_FREQ, 32'd100);
    volt <= 16'd99; curr <= 16'd399;
    sample();
    chk({t12, rly_a, rly_b}, 3'b110);
    apb(0, dso_pkg::OFS_FLAGS, 0);
    chk(rd[2:1], 2'b11);
    volt <= 16'd100; curr <= 16'd400;
    sample();
    chk({t12, rly_a, rly_b}, 3'b001);
    $display("test loss done");
  endtask

  task automatic t_boost;
    logic [15:0] fbs [6] = '{16'd50, 16'd150, 16'd250, 16'd150, 16'd50, 16'd150};
    logic        exp [6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
    apb(1, dso_pkg::OFS_TERM_CFG, 32'h00001F);
    apb(1, dso_pkg::OFS_PV_LOW, 32'd100);
    apb(1, dso_pkg::OFS_PV_HIGH, 32'd200);
    run_in <= 1'b0; fb <= 16'd50;
    sample();
    chk(t11, 1'b0);
    run_in <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      fb <= fbs[i];
      sample();
      chk(t11, exp[i]);
    end
    chk(motor, 1'b1);
    run_in <= 1'b0;
    repeat (7) @(posedge clk_sys);
    #1;
    chk(t11, 1'b0);
    repeat (4) @(posedge clk_sys);
    #1;
    chk(motor, 1'b0);
    $display("test boost done");
  endtask

  task automatic t_irq;
    apb(1, dso_pkg::OFS_IRQ_STS, 32'hF);
    apb(1, dso_pkg::OFS_IRQ_MASK, 32'h2);
    #1;
    chk(irq, 1'b0);
    volt <= 16'd10;
    sample();
    chk(irq, 1'b1);
    apb(0, dso_pkg::OFS_IRQ_STS, 0);    chk(rd[1], 1'b1);
    apb(1, dso_pkg::OFS_IRQ_MASK, 32'h0);
    #1;
    chk(irq, 1'b0);
    apb(1, dso_pkg::OFS_IRQ_MASK, 32'h2);
    apb(1, dso_pkg::OFS_IRQ_STS, 32'h2);
    #1;
    chk(irq, 1'b0);
    $display("test irq done");
  endtask

  initial begin
    clk_sys = 1'b0; rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; pstrb = 4'h0; pos_in = 1'b0; run_in = 1'b0;
    tick = 1'b0; volt = 16'd500; curr = 16'd1000; fb = 16'd0;
    failures = 0; cmp_count = 0;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    t_reset_regs();
    t_position();
    t_loss(1'b0);
    t_loss(1'b1);
    t_boost();
    t_irq();
    report_and_stop();
  end
endmodule
